//--- asd_adder.sv
// constants package and the parallel full-adder array of the datapath
`default_nettype none

package asd_pkg;
    localparam int unsigned WORD_W = 24;
    localparam int unsigned MAG_W = 23;
    localparam int unsigned SIGN_BIT = 23;
    localparam int unsigned ADDR_W = 11;
    localparam int unsigned BSLOTS = 4;
    localparam int unsigned BBITS_PER_WORD = 16;
    localparam int unsigned BWORDS = 128;
    localparam int unsigned BBIT_W = 4;
    localparam int unsigned BWORD_W = 7;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned MCYC_PS = 6105000;
    localparam int unsigned MCYC_CLKS = MCYC_PS / (CLK_PERIOD_NS * 1000);
    localparam int unsigned MD_MCYC_DEF = 4;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned MCNT_W = 4;
    localparam logic [23:0] ACC_RST = 24'h00_0000;
    localparam logic [23:0] SALV_RST = 24'h00_0000;
    localparam logic BACC_RST = 1'b0;
    localparam logic [3:0] BSALV_RST = 4'h0;

    typedef enum logic [3:0] {
        ASD_OP_NOP = 4'h0,
        ASD_OP_LOAD = 4'h1,
        ASD_OP_LOAD_DRUM = 4'h2,
        ASD_OP_STORE = 4'h3,
        ASD_OP_ADD = 4'h4,
        ASD_OP_SUB = 4'h5,
        ASD_OP_MUL = 4'h6,
        ASD_OP_DIV = 4'h7,
        ASD_OP_BAND = 4'h8,
        ASD_OP_BOR = 4'h9,
        ASD_OP_BCOMP = 4'hA,
        ASD_OP_BLOAD = 4'hB,
        ASD_OP_BSTORE = 4'hC
    } asd_op_t;

    typedef enum logic [1:0] {
        ASD_ST_IDLE = 2'b01,
        ASD_ST_RUN = 2'b10
    } asd_state_t;
endpackage : asd_pkg

module asd_adder #(
    parameter int unsigned W = asd_pkg::MAG_W
) (
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    input wire logic c_i,
    output logic [W-1:0] s_o,
    output logic c_o
);
    logic [W:0] carry;

    assign carry[0] = c_i;

    // one cell per bit pair, carries rippling left
    for (genvar i = 0; i < W; i++) begin : g_cell
        assign s_o[i] = a_i[i] ^ b_i[i] ^ carry[i];
        assign carry[i+1] = (a_i[i] & b_i[i])
            | (carry[i] & (a_i[i] ^ b_i[i]));
    end

    assign c_o = carry[W];
endmodule : asd_adder

`default_nettype wire

//--- asd_datapath.sv
// accumulator, salvage register and Boolean unit of the arithmetic datapath
`default_nettype none

module asd_datapath #(
    parameter int unsigned MD_MCYC = asd_pkg::MD_MCYC_DEF
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_op_i,
    input wire logic [10:0] cmd_addr_i,
    input wire logic cmd_use_salv_i,
    input wire logic [1:0] cmd_bslot_i,
    input wire logic [23:0] core_rdata_i,
    input wire logic [23:0] drum_rdata_i,
    output logic [23:0] acc_o,
    output logic [23:0] salv_o,
    output logic bacc_o,
    output logic [3:0] bsalv_o,
    output logic ovf_o,
    output logic busy_o,
    output logic done_o,
    output logic core_we_o,
    output logic [10:0] core_addr_o,
    output logic [23:0] core_wdata_o,
    output logic [23:0] core_wmask_o
);
    localparam int unsigned CW = asd_pkg::CNT_W;
    localparam int unsigned MW = asd_pkg::MCNT_W;
    localparam int unsigned MG = asd_pkg::MAG_W;
    localparam int unsigned SB = asd_pkg::SIGN_BIT;
    localparam logic [CW-1:0] TICK_LAST = CW'(asd_pkg::MCYC_CLKS - 1);
    localparam logic [MW-1:0] MD_LAST = MW'(MD_MCYC - 1);

    // one-hot select of a bit inside a Boolean word
    function automatic logic [23:0] bit_onehot(input logic [10:0] baddr);
        logic [23:0] m;
        m = 24'h00_0000;
        m[baddr[asd_pkg::BBIT_W-1:0]] = 1'b1;
        return m;
    endfunction : bit_onehot

    // core word that holds a Boolean location
    function automatic logic [10:0] bool_word(input logic [10:0] baddr);
        return {4'h0, baddr[asd_pkg::ADDR_W-1:asd_pkg::BBIT_W]};
    endfunction : bool_word

    asd_pkg::asd_state_t state_q;
    asd_pkg::asd_state_t state_d;
    asd_pkg::asd_op_t op_q;
    logic [CW-1:0] tick_q;
    logic [MW-1:0] mleft_q;
    logic [10:0] addr_q;
    logic [23:0] opnd_q;
    logic use_salv_q;
    logic [1:0] bslot_q;
    logic [23:0] acc_q;
    logic [23:0] salv_q;
    logic bacc_q;
    logic [3:0] bsalv_q;
    logic ovf_q;
    logic busy_q;
    logic done_q;
    logic core_we_q;
    logic [10:0] core_addr_q;
    logic [23:0] core_wdata_q;
    logic [23:0] core_wmask_q;

    logic take;
    logic commit;
    logic is_md;

    // arithmetic operand paths
    logic [23:0] b_word;
    logic b_sign;
    logic same_sign;
    logic [MG-1:0] a_mag;
    logic [MG-1:0] b_mag;
    logic [MG-1:0] add_b;
    logic [MG-1:0] s1;
    logic c1;
    logic [MG-1:0] s2;
    logic [23:0] addsub_res;
    logic addsub_ovf;
    logic [2*MG-1:0] prod;
    logic [2*MG-1:0] quot_full;
    logic [23:0] mul_res;
    logic [23:0] div_res;
    logic div_ovf;
    logic bool_opnd;

    // an op is accepted only while idle; commands seen while busy are dropped
    assign take = (state_q == asd_pkg::ASD_ST_IDLE)
        && cmd_valid_i;
    // commit falls on the last clock of the op's last machine cycle
    assign commit = (state_q == asd_pkg::ASD_ST_RUN) && (tick_q == TICK_LAST)
        && (mleft_q == '0);
    // multiply and divide run for several machine cycles
    assign is_md = (cmd_op_i == asd_pkg::ASD_OP_MUL)
        || (cmd_op_i == asd_pkg::ASD_OP_DIV);

    always_comb begin
        state_d = state_q;
        case (state_q)
            asd_pkg::ASD_ST_IDLE: begin
                if (take) begin
                    state_d = asd_pkg::ASD_ST_RUN;
                end
            end
            asd_pkg::ASD_ST_RUN: begin
                if (commit) begin
                    state_d = asd_pkg::ASD_ST_IDLE;
                end
            end
            default: begin
                state_d = asd_pkg::ASD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= asd_pkg::ASD_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // clocks within a machine cycle, and machine cycles still to run
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_q <= '0;
            mleft_q <= '0;
        end else if (take) begin
            tick_q <= '0;
            mleft_q <= is_md ? MD_LAST : '0;
        end else if (state_q == asd_pkg::ASD_ST_RUN) begin
            if (tick_q == TICK_LAST) begin
                tick_q <= '0;
                if (mleft_q != '0) begin
                    mleft_q <= mleft_q - MW'(1);
                end
            end else begin
                tick_q <= tick_q + CW'(1);
            end
        end
    end

    // command capture at acceptance
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            op_q <= asd_pkg::ASD_OP_NOP;
            addr_q <= '0;
            opnd_q <= '0;
            use_salv_q <= 1'b0;
            bslot_q <= '0;
        end else if (take) begin
            op_q <= asd_pkg::asd_op_t'(cmd_op_i);
            addr_q <= cmd_addr_i;
            // drum data is taken only for the dedicated drum load
            opnd_q <= (cmd_op_i == asd_pkg::ASD_OP_LOAD_DRUM)
                ? drum_rdata_i : core_rdata_i;
            use_salv_q <= cmd_use_salv_i;
            bslot_q <= cmd_bslot_i;
        end
    end

    // sign-magnitude add and subtract
    assign b_word = use_salv_q ? salv_q : opnd_q;
    assign b_sign = b_word[SB] ^ (op_q == asd_pkg::ASD_OP_SUB);
    assign same_sign = (acc_q[SB] == b_sign);
    assign a_mag = acc_q[MG-1:0];
    assign b_mag = b_word[MG-1:0];
    assign add_b = same_sign ? b_mag : ~b_mag;

    asd_adder #(
        .W(MG)
    ) u_add_main (
        .a_i(a_mag),
        .b_i(add_b),
        .c_i(~same_sign),
        .s_o(s1),
        .c_o(c1)
    );

    // reverse difference, used when the operand outweighs the accumulator
    asd_adder #(
        .W(MG)
    ) u_add_rev (
        .a_i(b_mag),
        .b_i(~a_mag),
        .c_i(1'b1),
        .s_o(s2),
        .c_o()
    );

    always_comb begin
        addsub_ovf = 1'b0;
        if (same_sign) begin
            addsub_res = {acc_q[SB], s1};
            addsub_ovf = c1;
        end else if (c1) begin
            // equal magnitudes give positive zero
            addsub_res = {acc_q[SB] & (s1 != '0), s1};
        end else begin
            addsub_res = {b_sign, s2};
        end
    end

    // fractional multiply and divide on magnitudes, sign by exclusive or
    assign prod = {{MG{1'b0}}, a_mag} * {{MG{1'b0}}, b_mag};
    assign quot_full = (b_mag == '0) ? '0 : {a_mag, {MG{1'b0}}}
        / {{MG{1'b0}}, b_mag};
    assign div_ovf = (a_mag >= b_mag);
    assign mul_res = {(acc_q[SB] ^ b_word[SB]) & (prod[2*MG-1:MG] != '0),
        prod[2*MG-1:MG]};
    assign div_res = div_ovf ? {acc_q[SB] ^ b_word[SB], {MG{1'b1}}}
        : {(acc_q[SB] ^ b_word[SB]) & (quot_full[MG-1:0] != '0),
        quot_full[MG-1:0]};

    // Boolean operand: addressed core bit or a salvage slot
    always_comb begin
        if (use_salv_q) begin
            bool_opnd = bsalv_q[bslot_q];
        end else begin
            bool_opnd = |(opnd_q & bit_onehot(addr_q));
        end
    end

    // arithmetic accumulator and its salvage register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= asd_pkg::ACC_RST;
            salv_q <= asd_pkg::SALV_RST;
            ovf_q <= 1'b0;
        end else if (commit) begin
            case (op_q)
                asd_pkg::ASD_OP_LOAD, asd_pkg::ASD_OP_LOAD_DRUM: begin
                    // only data operands reach here; salvage never does
                    acc_q <= opnd_q;
                    salv_q <= acc_q;
                end
                asd_pkg::ASD_OP_ADD, asd_pkg::ASD_OP_SUB: begin
                    acc_q <= addsub_res;
                    ovf_q <= addsub_ovf;
                end
                asd_pkg::ASD_OP_MUL: begin
                    acc_q <= mul_res;
                    ovf_q <= 1'b0;
                end
                asd_pkg::ASD_OP_DIV: begin
                    acc_q <= div_res;
                    ovf_q <= div_ovf;
                end
                default: begin
                    acc_q <= acc_q;
                end
            endcase
        end
    end

    // Boolean accumulator and four-slot salvage
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bacc_q <= asd_pkg::BACC_RST;
            bsalv_q <= asd_pkg::BSALV_RST;
        end else if (commit) begin
            case (op_q)
                asd_pkg::ASD_OP_BLOAD: begin
                    bacc_q <= bool_opnd & ~use_salv_q;
                    bsalv_q <= {bsalv_q[2:0], bacc_q};
                end
                asd_pkg::ASD_OP_BAND: begin
                    bacc_q <= bacc_q & bool_opnd;
                end
                asd_pkg::ASD_OP_BOR: begin
                    bacc_q <= bacc_q | bool_opnd;
                end
                asd_pkg::ASD_OP_BCOMP: begin
                    bacc_q <= ~bacc_q;
                end
                default: begin
                    bacc_q <= bacc_q;
                end
            endcase
        end
    end

    // core write port: arithmetic and Boolean stores
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            core_we_q <= 1'b0;
            core_addr_q <= '0;
            core_wdata_q <= '0;
            core_wmask_q <= '0;
        end else begin
            core_we_q <= 1'b0;
            if (commit && (op_q == asd_pkg::ASD_OP_STORE)) begin
                core_we_q <= 1'b1;
                core_addr_q <= addr_q;
                core_wdata_q <= acc_q;
                core_wmask_q <= 24'hFF_FFFF;
            end else if (commit && (op_q == asd_pkg::ASD_OP_BSTORE)) begin
                // only the accumulator bit, into the Boolean core words
                core_we_q <= 1'b1;
                core_addr_q <= bool_word(addr_q);
                core_wdata_q <= bacc_q ? bit_onehot(addr_q) : '0;
                core_wmask_q <= bit_onehot(addr_q);
            end
        end
    end

    // busy spans the whole operation; done marks the commit edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= commit;
            if (take) begin
                busy_q <= 1'b1;
            end else if (commit) begin
                busy_q <= 1'b0;
            end
        end
    end

    assign acc_o = acc_q;
    assign salv_o = salv_q;
    assign bacc_o = bacc_q;
    assign bsalv_o = bsalv_q;
    assign ovf_o = ovf_q;
    assign busy_o = busy_q;
    assign done_o = done_q;
    assign core_we_o = core_we_q;
    assign core_addr_o = core_addr_q;
    assign core_wdata_o = core_wdata_q;
    assign core_wmask_o = core_wmask_q;
endmodule : asd_datapath

`default_nettype wire

//--- asd_core_model.sv
// core memory model standing behind the datapath write port
`default_nettype none
module asd_core_model (
    input wire logic mclk_i,
    input wire logic we_i,
    input wire logic [10:0] addr_i,
    input wire logic [23:0] wdata_i,
    input wire logic [23:0] wmask_i,
    input wire logic [10:0] raddr_i,
    output logic [23:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] mem [2048];
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 24'h00_0000;
        end
    end
    // masked write keeps untouched bits of the word
    always @(posedge mclk_i) begin
        if (we_i) begin
            mem[addr_i] <= (mem[addr_i] & ~wmask_i)
                | (wdata_i & wmask_i);
        end
    end
    assign rdata_o = mem[raddr_i];
endmodule : asd_core_model
`default_nettype wire

//--- asd_datapath_props.sv
// assertions on the ports of the datapath
`default_nettype none
module asd_datapath_props #(
    parameter int unsigned MD_MCYC = asd_pkg::MD_MCYC_DEF
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_op_i,
    input wire logic [10:0] cmd_addr_i,
    input wire logic cmd_use_salv_i,
    input wire logic [1:0] cmd_bslot_i,
    input wire logic [23:0] core_rdata_i,
    input wire logic [23:0] drum_rdata_i,
    input wire logic [23:0] acc_o,
    input wire logic [23:0] salv_o,
    input wire logic bacc_o,
    input wire logic [3:0] bsalv_o,
    input wire logic ovf_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic core_we_o,
    input wire logic [10:0] core_addr_o,
    input wire logic [23:0] core_wdata_o,
    input wire logic [23:0] core_wmask_o
);
    localparam int SC = int'(asd_pkg::MCYC_CLKS);
    logic [3:0] op_q;
    logic [10:0] addr_q;
    logic [23:0] rd_q;
    logic [23:0] acc_q;
    logic [15:0] cnt_q;
    logic [15:0] exp_c;
    logic md;
    logic is_load;
    assign md = (op_q == 4'h6) || (op_q == 4'h7);
    assign is_load = (op_q == 4'h1) || (op_q == 4'h2);
    assign exp_c = md ? 16'(SC * MD_MCYC + 1) : 16'(SC + 1);
    // command capture and cycles since the take
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            op_q <= 4'h0;
            addr_q <= 11'h000;
            rd_q <= 24'h00_0000;
            acc_q <= 24'h00_0000;
            cnt_q <= 16'h0000;
        end else if (cmd_valid_i && !busy_o) begin
            op_q <= cmd_op_i;
            addr_q <= cmd_addr_i;
            rd_q <= (cmd_op_i == 4'h2) ? drum_rdata_i : core_rdata_i;
            acc_q <= acc_o;
            cnt_q <= 16'h0001;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_take;
        cmd_valid_i && !busy_o;
    endsequence
    sequence s_commit;
        $fell(busy_o);
    endsequence
    sequence s_done_pulse;
        done_o ##1 !done_o;
    endsequence
    sequence s_bstore;
        core_we_o && op_q == 4'hC;
    endsequence
    a_busy_on_take: assert property (s_take |-> ##1 busy_o)
        else $error("busy missing after a take");
    a_commit_time: assert property (s_commit |-> cnt_q == exp_c)
        else $error("commit at wrong cycle");
    a_done_pulse: assert property (s_commit |-> s_done_pulse)
        else $error("done pulse wrong");
    a_load_salvage: assert property (s_commit ##0 is_load
        |-> acc_o == rd_q && salv_o == acc_q)
        else $error("load or salvage value wrong");
    a_salv_kept: assert property (s_commit ##0 op_q[3:2] == 2'b01
        |-> $stable(salv_o))
        else $error("arithmetic changed salvage");
    a_we_commit: assert property (core_we_o |-> $fell(busy_o)
        && (op_q == 4'h3 || op_q == 4'hC) ##1 !core_we_o)
        else $error("write strobe outside a store commit");
    a_store_word: assert property (core_we_o && op_q == 4'h3 |->
        core_wdata_o == acc_o && core_wmask_o == 24'hFF_FFFF &&
        core_addr_o == addr_q)
        else $error("store word wrong");
    a_bstore_bit: assert property (s_bstore |->
        core_addr_o == {4'h0, addr_q[10:4]} &&
        core_wmask_o == 24'h00_0001 << addr_q[3:0] &&
        core_wdata_o[addr_q[3:0]] == bacc_o)
        else $error("boolean store wrong");
    a_bload_shift: assert property (s_commit ##0 op_q == 4'hB |->
        bsalv_o == {$past(bsalv_o[2:0]), $past(bacc_o)})
        else $error("boolean salvage shift wrong");
    a_bcomp_inv: assert property (s_commit ##0 op_q == 4'hA |->
        bacc_o != $past(bacc_o) && $stable(bsalv_o))
        else $error("complement wrong");
endmodule : asd_datapath_props
bind asd_datapath asd_datapath_props #(.MD_MCYC(MD_MCYC))
    i_asd_datapath_props (.*);
`default_nettype wire

//--- test_accumulator_salvage_datapath.sv
// self-checking bench for the accumulator salvage datapath
`default_nettype none
module test_accumulator_salvage_datapath;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned MD = 2;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic [3:0] cmd_op_i = 4'h0;
    logic [10:0] cmd_addr_i = 11'h000;
    logic cmd_use_salv_i = 1'b0;
    logic [1:0] cmd_bslot_i = 2'h0;
    logic [23:0] core_rdata_i = 24'h00_0000;
    logic [23:0] drum_rdata_i = 24'h00_0000;
    logic [23:0] acc_o, salv_o, core_wdata_o, core_wmask_o, mrd;
    logic bacc_o, ovf_o, busy_o, done_o, core_we_o;
    logic [3:0] bsalv_o;
    logic [10:0] core_addr_o;
    logic [10:0] raddr = 11'h001;
    int fail_count = 0;
    int cmp_count = 0;
    int lat = 0;
    int we_cnt = 0;
    asd_datapath #(.MD_MCYC(MD)) i_asd_datapath (.*);
    asd_core_model i_asd_core_model (.mclk_i(mclk_i), .we_i(core_we_o),
        .addr_i(core_addr_o), .wdata_i(core_wdata_o),
        .wmask_i(core_wmask_o), .raddr_i(raddr), .rdata_o(mrd));
    always #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (core_we_o === 1'b1) we_cnt++;
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic wt();
        lat = 0;
        while (done_o !== 1'b1 && lat < 400) begin
            @(negedge mclk_i);
            lat++;
        end
        if (lat >= 400) begin
            fail_count++;
            summarize();
        end
    endtask : wt
    task automatic run(input logic [3:0] op, input logic [10:0] a,
            input logic us, input logic [1:0] sl, input logic [23:0] d);
        @(negedge mclk_i);
        cmd_op_i = op;
        cmd_addr_i = a;
        cmd_use_salv_i = us;
        cmd_bslot_i = sl;
        core_rdata_i = d;
        drum_rdata_i = ~d;
        cmd_valid_i = 1'b1;
        @(negedge mclk_i);
        cmd_valid_i = 1'b0;
        wt();
    endtask : run
    task automatic t_load();
        chk(acc_o, 24'h00_0000);
        chk(salv_o, 24'h00_0000);
        run(4'h1, 11'h000, 1'b0, 2'h0, 24'h12_3456);
        chk(24'(lat), 24'(asd_pkg::MCYC_CLKS));
        run(4'h1, 11'h000, 1'b0, 2'h0, 24'h80_0007);
        chk(acc_o, 24'h80_0007);
        chk(salv_o, 24'h12_3456);
        run(4'h2, 11'h000, 1'b0, 2'h0, 24'hFF_FFF0);
        chk(acc_o, 24'h00_000F);
        chk(salv_o, 24'h80_0007);
        $display("t_load done");
    endtask : t_load
    task automatic t_arith();
        run(4'h4, 11'h000, 1'b0, 2'h0, 24'h3F_FFF1);
        chk(acc_o, 24'h40_0000);
        run(4'h4, 11'h000, 1'b1, 2'h0, 24'h00_0000);
        chk(acc_o, 24'h3F_FFF9);
        chk(salv_o, 24'h80_0007);
        run(4'h5, 11'h000, 1'b0, 2'h0, 24'h40_0000);
        chk(acc_o, 24'h80_0007);
        run(4'h4, 11'h000, 1'b0, 2'h0, 24'h7F_FFFF);
        chk(acc_o, 24'h7F_FFF8);
        chk({23'h0, ovf_o}, 24'h00_0000);
        run(4'h4, 11'h000, 1'b0, 2'h0, 24'h00_0008);
        chk({23'h0, ovf_o}, 24'h00_0001);
        $display("t_arith done");
    endtask : t_arith
    task automatic t_muldiv();
        run(4'h1, 11'h000, 1'b0, 2'h0, 24'h40_0000);
        run(4'h6, 11'h000, 1'b0, 2'h0, 24'hC0_0000);
        chk(acc_o, 24'hA0_0000);
        chk(24'(lat), 24'(asd_pkg::MCYC_CLKS * MD));
        run(4'h7, 11'h000, 1'b0, 2'h0, 24'h40_0000);
        chk(acc_o, 24'hC0_0000);
        run(4'h7, 11'h000, 1'b0, 2'h0, 24'h00_0000);
        chk({23'h0, ovf_o}, 24'h00_0001);
        chk(acc_o & 24'h7F_FFFF, 24'h7F_FFFF);
        $display("t_muldiv done");
    endtask : t_muldiv
    task automatic t_store();
        int w;
        w = we_cnt;
        run(4'h1, 11'h000, 1'b0, 2'h0, 24'h00_A5C3);
        run(4'h3, 11'h001, 1'b0, 2'h0, 24'h00_0000);
        // the write lands on the edge after the strobe
        @(negedge mclk_i);
        chk(mrd, 24'h00_A5C3);
        chk(24'(we_cnt - w), 24'h00_0001);
        $display("t_store done");
    endtask : t_store
    task automatic t_bool();
        logic [3:0] b [6] = '{4'h0, 4'h2, 4'h1, 4'h3, 4'h6, 4'h0};
        logic [3:0] op [6] = '{4'h8, 4'h9, 4'h8, 4'h9, 4'hA, 4'hA};
        logic us [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        logic [3:0] k [6] = '{4'h1, 4'h2, 4'h2, 4'h7, 4'h0, 4'h0};
        logic eb;
        logic o;
        logic [3:0] es;
        eb = 1'b0;
        es = 4'h0;
        for (int i = 0; i < 6; i++) begin
            run(4'hB, {7'h01, b[i]}, 1'b0, 2'h0, mrd);
            es = {es[2:0], eb};
            eb = mrd[b[i]];
            chk({23'h0, bacc_o}, {23'h0, eb});
            chk({20'h0, bsalv_o}, {20'h0, es});
        end
        for (int i = 0; i < 6; i++) begin
            run(op[i], {7'h01, k[i]}, us[i], k[i][1:0], mrd);
            o = us[i] ? es[k[i][1:0]] : mrd[k[i]];
            eb = (op[i] == 4'h8) ? eb & o : (op[i] == 4'h9) ? eb | o : ~eb;
            chk({23'h0, bacc_o}, {23'h0, eb});
            chk({20'h0, bsalv_o}, {20'h0, es});
        end
        run(4'hC, 11'h025, 1'b0, 2'h0, 24'h00_0000);
        raddr = 11'h002;
        @(negedge mclk_i);
        chk(mrd, 24'h00_0020);
        $display("t_bool done");
    endtask : t_bool
    task automatic t_refuse();
        int w;
        w = we_cnt;
        @(negedge mclk_i);
        cmd_op_i = 4'h6;
        cmd_use_salv_i = 1'b0;
        core_rdata_i = 24'h40_0000;
        cmd_valid_i = 1'b1;
        @(negedge mclk_i);
        cmd_valid_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        cmd_op_i = 4'h3;
        cmd_addr_i = 11'h003;
        cmd_valid_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        cmd_valid_i = 1'b0;
        wt();
        chk(acc_o, 24'h00_52E1);
        chk(24'(we_cnt - w), 24'h00_0000);
        $display("t_refuse done");
    endtask : t_refuse
    initial begin
        repeat (8) @(posedge mclk_i);
        @(negedge mclk_i);
        rst_i = 1'b0;
        t_load();
        t_arith();
        t_muldiv();
        t_store();
        t_bool();
        t_refuse();
        summarize();
    end
endmodule : test_accumulator_salvage_datapath
`default_nettype wire
